// [include/sim_consts.vh]
// Constants for the safety interlock monitor
// How it works
// - Door pair mismatch two seconds: critical error
// - Stop pair mismatch two seconds: critical error
// - Door-open and teach flags stay latched
// - Release open captures; release closed clears
// - Open door keeps power prohibited anyway
// - Door open holds program, prohibits power
// - Stop holds until release, then reset
// - Stop indicator lit until release and reset
// - Unconnected inputs read open, stop active
`ifndef SIM_CONSTS_VH
`define SIM_CONSTS_VH

// ==========================================
// Timing
`define SIM_CLK_HZ 100000000
`define SIM_DISC_TIME_MS 2000
`define SIM_DISC_CYCLES (`SIM_DISC_TIME_MS * (`SIM_CLK_HZ / 1000))
`define SIM_DEBOUNCE_TIME_US 1000
`define SIM_DEBOUNCE_CYCLES (`SIM_DEBOUNCE_TIME_US * (`SIM_CLK_HZ / 1000000))

// ==========================================
// Register byte offsets
`define SIM_OFS_STATUS 4'h0
`define SIM_OFS_MASK 4'h4
`define SIM_OFS_CONTROL 4'h8
`define SIM_OFS_STATE 4'hC

// ==========================================
// Event bits of status and mask
`define SIM_EV_DOOR_OPEN 0
`define SIM_EV_TEACH 1
`define SIM_EV_ESTOP 2
`define SIM_EV_CRIT_DOOR 3
`define SIM_EV_CRIT_ESTOP 4
`define SIM_EV_W 5

// ==========================================
// Control bits
`define SIM_CTL_RESET_CMD 0

// ==========================================
// State register bits
`define SIM_ST_ESTOP 0
`define SIM_ST_DOOR_LATCH 1
`define SIM_ST_TEACH_LATCH 2
`define SIM_ST_PROHIBIT 3
`define SIM_ST_HOLD 4
`define SIM_ST_CRIT 5
`define SIM_ST_DOOR_OPEN 6
`define SIM_ST_RELEASED 7

// ==========================================
// Reset values
`define SIM_MASK_RST 5'h00
`define SIM_STATUS_RST 5'h00

// ==========================================
// Bus responses
`define SIM_RESP_OKAY 2'h0
`define SIM_RESP_SLVERR 2'h2

`endif

// [design/sim_debounce.v]
// Input synchroniser and contact bounce filter
`timescale 1ns/1ps
`default_nettype none

module sim_debounce #(
    parameter [31:0] DEBOUNCE_CYCLES = 32'd100000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Raw and filtered level
    input wire raw_in,
    output reg level_r
);

    reg sync1_r;
    reg sync2_r;
    reg [31:0] cnt_r;

    // ==========================================
    // Two-stage synchroniser, then stable-time filter
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r <= 32'h00000000;
            level_r <= 1'b0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            if (sync2_r == level_r) begin
                cnt_r <= 32'h00000000;
            end else if (cnt_r >= DEBOUNCE_CYCLES - 32'd1) begin
                cnt_r <= 32'h00000000;
                level_r <= sync2_r;
            end else begin
                cnt_r <= cnt_r + 32'd1;
            end
        end
    end

endmodule

`default_nettype wire

// [design/sim_monitor.v]
// Safety interlock monitor with AXI4-Lite register access
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sim_consts.vh"

module sim_monitor #(
    parameter [31:0] DISC_CYCLES = `SIM_DISC_CYCLES,
    parameter [31:0] DEBOUNCE_CYCLES = `SIM_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Safety inputs, high means contact closed
    input wire door_channel_a_pin1,
    input wire door_channel_b_pin1,
    input wire stop_circuit_a_pos,
    input wire stop_circuit_b_pos,
    input wire latch_release_in,
    input wire teach_mode_in,
    // Safety outputs
    output reg estop_active_r,
    output reg estop_led_r,
    output reg door_latch_r,
    output reg teach_latch_r,
    output reg power_prohibit_r,
    output reg program_hold_r,
    output reg critical_err_r,
    output reg irq_r,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam [2:0] ST_STOP = 3'b001;
    localparam [2:0] ST_RELEASED = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;

    // ==========================================
    // Filtered inputs
    wire [5:0] raw_in;
    wire [5:0] filt;
    assign raw_in = {teach_mode_in, latch_release_in, stop_circuit_b_pos,
                     stop_circuit_a_pos, door_channel_b_pin1, door_channel_a_pin1};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_filt
            sim_debounce #(
                .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
            ) u_deb (
                .aclk(aclk),
                .aresetn(aresetn),
                .raw_in(raw_in[gi]),
                .level_r(filt[gi])
            );
        end
    endgenerate

    wire door_open;
    wire stop_pressed;
    wire latch_closed;
    wire teach_on;
    assign door_open = ~(filt[0] & filt[1]);
    assign stop_pressed = ~(filt[2] & filt[3]);
    assign latch_closed = filt[4];
    assign teach_on = filt[5];

    // ==========================================
    // Pair discrepancy timers
    wire [1:0] pair_diff;
    wire [1:0] crit_hit;
    wire [1:0] crit_flag;
    wire reset_cmd;
    assign pair_diff = {filt[2] ^ filt[3], filt[0] ^ filt[1]};

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_disc
            reg [31:0] cnt_r;
            reg flag_r;
            assign crit_hit[gi] = pair_diff[gi] && (cnt_r >= DISC_CYCLES - 32'd1);
            assign crit_flag[gi] = flag_r;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_r <= 32'h00000000;
                    flag_r <= 1'b0;
                end else begin
                    if (!pair_diff[gi]) begin
                        cnt_r <= 32'h00000000;
                    end else if (!crit_hit[gi]) begin
                        cnt_r <= cnt_r + 32'd1;
                    end
                    if (crit_hit[gi]) begin
                        flag_r <= 1'b1;
                    end else if (reset_cmd && !pair_diff[gi]) begin
                        flag_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // Door and teach latches
    reg door_latch_nxt;
    reg teach_latch_nxt;
    always @* begin
        if (latch_closed) begin
            door_latch_nxt = door_open;
            teach_latch_nxt = teach_on;
        end else begin
            door_latch_nxt = door_latch_r | door_open;
            teach_latch_nxt = teach_latch_r | teach_on;
        end
    end

    // ==========================================
    // Emergency stop sequence
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    wire stop_cause;
    assign stop_cause = stop_pressed | (|crit_flag);

    always @* begin
        case (state_r)
            ST_STOP: begin
                state_nxt = stop_cause ? ST_STOP : ST_RELEASED;
            end
            ST_RELEASED: begin
                if (stop_cause) begin
                    state_nxt = ST_STOP;
                end else if (reset_cmd) begin
                    state_nxt = ST_RUN;
                end else begin
                    state_nxt = ST_RELEASED;
                end
            end
            ST_RUN: begin
                state_nxt = stop_cause ? ST_STOP : ST_RUN;
            end
            default: begin
                state_nxt = ST_STOP;
            end
        endcase
    end

    // ==========================================
    // Events, status and outputs
    reg [4:0] status_r;
    reg [4:0] mask_r;
    reg door_open_d_r;
    wire [4:0] ev;
    wire status_rd;
    assign ev[`SIM_EV_DOOR_OPEN] = door_open & ~door_open_d_r;
    assign ev[`SIM_EV_TEACH] = teach_latch_nxt & ~teach_latch_r;
    assign ev[`SIM_EV_ESTOP] = (state_nxt == ST_STOP) & (state_r != ST_STOP);
    assign ev[`SIM_EV_CRIT_DOOR] = crit_hit[0] & ~crit_flag[0];
    assign ev[`SIM_EV_CRIT_ESTOP] = crit_hit[1] & ~crit_flag[1];

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_STOP;
            door_open_d_r <= 1'b1;
            status_r <= `SIM_STATUS_RST;
            estop_active_r <= 1'b1;
            estop_led_r <= 1'b1;
            door_latch_r <= 1'b1;
            teach_latch_r <= 1'b0;
            power_prohibit_r <= 1'b1;
            program_hold_r <= 1'b1;
            critical_err_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            door_open_d_r <= door_open;
            door_latch_r <= door_latch_nxt;
            teach_latch_r <= teach_latch_nxt;
            estop_active_r <= (state_nxt != ST_RUN);
            estop_led_r <= (state_nxt != ST_RUN);
            program_hold_r <= door_open | door_latch_nxt;
            power_prohibit_r <= door_open | door_latch_nxt | teach_latch_nxt
                                | (state_nxt != ST_RUN);
            critical_err_r <= |(crit_flag | crit_hit);
            status_r <= (status_rd ? 5'h00 : status_r) | ev;
            irq_r <= |(((status_rd ? 5'h00 : status_r) | ev) & mask_r);
        end
    end

    // ==========================================
    // AXI4-Lite write path
    reg aw_got_r;
    reg w_got_r;
    reg [3:0] waddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg reset_cmd_r;
    wire wr_go;
    wire wr_map;
    assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign wr_map = (waddr_r == `SIM_OFS_STATUS) || (waddr_r == `SIM_OFS_MASK)
                    || (waddr_r == `SIM_OFS_CONTROL) || (waddr_r == `SIM_OFS_STATE);
    assign reset_cmd = reset_cmd_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SIM_RESP_OKAY;
            mask_r <= `SIM_MASK_RST;
            reset_cmd_r <= 1'b0;
        end else begin
            reset_cmd_r <= 1'b0;
            s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                waddr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `SIM_RESP_OKAY : `SIM_RESP_SLVERR;
                if (waddr_r == `SIM_OFS_MASK && wstrb_r[0]) begin
                    mask_r <= wdata_r[4:0];
                end
                if (waddr_r == `SIM_OFS_CONTROL && wstrb_r[0]) begin
                    reset_cmd_r <= wdata_r[`SIM_CTL_RESET_CMD];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // AXI4-Lite read path
    reg [31:0] rd_val;
    reg rd_map;
    wire [3:0] raddr;
    assign raddr = {s_axi_araddr[3:2], 2'b00};
    assign status_rd = s_axi_arvalid & s_axi_arready & (raddr == `SIM_OFS_STATUS);

    always @* begin
        rd_val = 32'h00000000;
        rd_map = 1'b1;
        case (raddr)
            `SIM_OFS_STATUS: rd_val[4:0] = status_r | ev;
            `SIM_OFS_MASK: rd_val[4:0] = mask_r;
            `SIM_OFS_CONTROL: rd_val = 32'h00000000;
            `SIM_OFS_STATE: begin
                rd_val[`SIM_ST_ESTOP] = estop_active_r;
                rd_val[`SIM_ST_DOOR_LATCH] = door_latch_r;
                rd_val[`SIM_ST_TEACH_LATCH] = teach_latch_r;
                rd_val[`SIM_ST_PROHIBIT] = power_prohibit_r;
                rd_val[`SIM_ST_HOLD] = program_hold_r;
                rd_val[`SIM_ST_CRIT] = critical_err_r;
                rd_val[`SIM_ST_DOOR_OPEN] = door_open;
                rd_val[`SIM_ST_RELEASED] = (state_r == ST_RELEASED);
            end
            default: rd_map = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SIM_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_map ? `SIM_RESP_OKAY : `SIM_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [dv/sim_checker.sv]
// Assertion checker for the safety interlock monitor
`timescale 1ns/1ps
`default_nettype none
module sim_checker #(
    parameter [31:0] DISC_CYCLES = 32'h14,
    parameter [31:0] DEBOUNCE_CYCLES = 32'h3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Safety inputs
    input wire logic door_channel_a_pin1,
    input wire logic door_channel_b_pin1,
    input wire logic stop_circuit_a_pos,
    input wire logic stop_circuit_b_pos,
    input wire logic latch_release_in,
    // Safety outputs
    input wire logic estop_active_r,
    input wire logic estop_led_r,
    input wire logic door_latch_r,
    input wire logic teach_latch_r,
    input wire logic power_prohibit_r,
    input wire logic program_hold_r,
    input wire logic critical_err_r,
    // Write response
    input wire logic s_axi_bvalid
);
localparam int LAG = DEBOUNCE_CYCLES + 6;
localparam int DLIM = DISC_CYCLES + LAG;
int cd;
int cx;
int cs;
int cl;
// ==========================================
// Consecutive-cycle counters
always_ff @(posedge aclk) begin
    cd <= (aresetn && door_channel_a_pin1 != door_channel_b_pin1) ? cd + (cd < DLIM) : 0;
    cx <= (aresetn && stop_circuit_a_pos != stop_circuit_b_pos) ? cx + (cx < DLIM) : 0;
    cs <= (aresetn && !stop_circuit_a_pos) ? cs + (cs < LAG) : 0;
    cl <= (aresetn && !latch_release_in) ? cl + (cl < LAG) : 0;
end
// ==========================================
// Properties
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_led;
    estop_led_r == estop_active_r;
endproperty
a_led: assert property (p_led) else $error("stop indicator differs from stop state");
property p_prohibit;
    (estop_active_r || door_latch_r || teach_latch_r) |-> ##[0:1] power_prohibit_r;
endproperty
a_prohibit: assert property (p_prohibit) else $error("power not prohibited");
property p_hold;
    door_latch_r |-> ##[0:1] program_hold_r;
endproperty
a_hold: assert property (p_hold) else $error("program not held with door latched");
property p_door_disc;
    cd == DLIM |-> critical_err_r;
endproperty
a_door_disc: assert property (p_door_disc) else $error("door mismatch without error");
property p_stop_disc;
    cx == DLIM |-> critical_err_r;
endproperty
a_stop_disc: assert property (p_stop_disc) else $error("stop mismatch without error");
property p_stop_open;
    cs == LAG |-> estop_active_r;
endproperty
a_stop_open: assert property (p_stop_open) else $error("open stop channel not stopping");
property p_latch;
    cl == LAG |=> !$fell(door_latch_r) && !$fell(teach_latch_r);
endproperty
a_latch: assert property (p_latch) else $error("latch dropped while release open");
property p_stop_exit;
    $fell(estop_active_r) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
endproperty
a_stop_exit: assert property (p_stop_exit) else $error("stop left without reset command");
endmodule
bind sim_monitor sim_checker #(.DISC_CYCLES(DISC_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_sim_checker (.*);
`default_nettype wire

// [dv/sim_switch_model.sv]
// Redundant door and stop switch model
`timescale 1ns/1ps
`default_nettype none
module sim_switch_model (
    // Clock
    input wire logic aclk,
    // Scenario controls
    input wire logic connected,
    input wire logic door_closed,
    input wire logic stop_released,
    input wire logic door_split,
    input wire logic stop_split,
    input wire logic bounce,
    // Contact channels
    output logic door_channel_a_pin1,
    output logic door_channel_b_pin1,
    output logic stop_circuit_a_pos,
    output logic stop_circuit_b_pos
);
logic tog = 1'h0;
always @(posedge aclk) tog <= ~tog;
// Unplugged connector reads open
assign door_channel_a_pin1 = connected & (bounce ? tog : door_closed);
assign door_channel_b_pin1 = connected & (door_closed ^ door_split);
assign stop_circuit_a_pos = connected & stop_released;
assign stop_circuit_b_pos = connected & (stop_released ^ stop_split);
endmodule
`default_nettype wire

// [dv/test_safety_interlock_monitor.sv]
// Self-checking bench for the safety interlock monitor
`timescale 1ns/1ps
`default_nettype none
`include "sim_consts.vh"
module test_safety_interlock_monitor;
localparam int DISC = 20;
logic aclk, aresetn, latch_release_in, teach_mode_in, connected, door_closed, stop_released;
logic door_split, stop_split, bounce, door_channel_a_pin1, door_channel_b_pin1;
logic stop_circuit_a_pos, stop_circuit_b_pos, estop_active_r, estop_led_r, door_latch_r;
logic teach_latch_r, power_prohibit_r, program_hold_r, critical_err_r, irq_r;
logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
logic [31:0] s_axi_wdata, s_axi_rdata, d;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [1:0] s_axi_bresp, s_axi_rresp;
int mismatches = 0;
int checked = 0;
int cyc = 0;
sim_monitor #(.DISC_CYCLES(DISC), .DEBOUNCE_CYCLES(3)) u_sim_monitor (.*);
sim_switch_model u_sim_switch_model (.*);
always #5 aclk = ~aclk;
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
        mismatches++;
        tally_and_finish;
    end
end
// ==========================================
// Tasks
task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
endtask
task automatic st;
    repeat (14) @(posedge aclk);
endtask
task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    bh = 1'h0;
    while (!bh) begin
        @(negedge aclk);
        ah = s_axi_awvalid & s_axi_awready;
        wh = s_axi_wvalid & s_axi_wready;
        bh = s_axi_bready & s_axi_bvalid;
        if (bh) chk("bresp", s_axi_bresp, `SIM_RESP_OKAY);
        @(posedge aclk);
        if (ah) s_axi_awvalid <= 1'h0;
        if (wh) s_axi_wvalid <= 1'h0;
        if (bh) s_axi_bready <= 1'h0;
    end
endtask
task automatic rd(input logic [3:0] a, output logic [31:0] v);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    rh = 1'h0;
    while (!rh) begin
        @(negedge aclk);
        ah = s_axi_arvalid & s_axi_arready;
        rh = s_axi_rready & s_axi_rvalid;
        v = s_axi_rdata;
        if (rh) chk("rresp", s_axi_rresp, `SIM_RESP_OKAY);
        @(posedge aclk);
        if (ah) s_axi_arvalid <= 1'h0;
        if (rh) s_axi_rready <= 1'h0;
    end
endtask
// ==========================================
// Main sequence
initial begin
    {aclk, aresetn, latch_release_in, teach_mode_in, connected, door_split, stop_split, bounce} = 8'h0;
    {door_closed, stop_released, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h18;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    st;
    chk("stop_unplugged", estop_active_r, 32'h1);
    chk("led_unplugged", estop_led_r, 32'h1);
    rd(`SIM_OFS_MASK, d);
    chk("mask_reset", d, 32'h0);
    connected <= 1'h1;
    stop_released <= 1'h0;
    latch_release_in <= 1'h1;
    st;
    wr(`SIM_OFS_CONTROL, 32'h1);
    st;
    chk("stop_pressed", estop_active_r, 32'h1);
    stop_released <= 1'h1;
    st;
    chk("stop_no_cmd", estop_led_r, 32'h1);
    rd(`SIM_OFS_STATE, d);
    chk("released", d[`SIM_ST_RELEASED], 32'h1);
    wr(`SIM_OFS_CONTROL, 32'h1);
    st;
    chk("stop_run", estop_active_r, 32'h0);
    chk("led_off", estop_led_r, 32'h0);
    chk("run_power", power_prohibit_r, 32'h0);
    rd(`SIM_OFS_STATUS, d);
    chk("status_idle", d, 32'h0);
    latch_release_in <= 1'h0;
    door_closed <= 1'h0;
    st;
    chk("door_latch", door_latch_r, 32'h1);
    chk("door_hold", program_hold_r, 32'h1);
    chk("irq_masked", irq_r, 32'h0);
    rd(`SIM_OFS_STATUS, d);
    chk("door_event", d[`SIM_EV_DOOR_OPEN], 32'h1);
    door_closed <= 1'h1;
    st;
    chk("latch_kept", door_latch_r, 32'h1);
    latch_release_in <= 1'h1;
    st;
    chk("latch_clr", door_latch_r, 32'h0);
    chk("power_ok", power_prohibit_r, 32'h0);
    latch_release_in <= 1'h0;
    teach_mode_in <= 1'h1;
    st;
    teach_mode_in <= 1'h0;
    door_closed <= 1'h0;
    st;
    chk("teach_kept", teach_latch_r, 32'h1);
    latch_release_in <= 1'h1;
    st;
    chk("teach_clr", teach_latch_r, 32'h0);
    chk("door_blocks", power_prohibit_r, 32'h1);
    door_closed <= 1'h1;
    st;
    chk("power_back", power_prohibit_r, 32'h0);
    bounce <= 1'h1;
    repeat (30) begin
        @(posedge aclk);
        chk("bounce", program_hold_r, 32'h0);
    end
    bounce <= 1'h0;
    wr(`SIM_OFS_MASK, 32'h18);
    rd(`SIM_OFS_STATUS, d);
    chk("events", d, 32'h3);
    for (int k = 0; k < 2; k++) begin
        door_split <= (k == 0);
        stop_split <= (k == 1);
        repeat (10) @(posedge aclk);
        chk("crit_short", critical_err_r, 32'h0);
        repeat (DISC + 10) @(posedge aclk);
        chk("crit", critical_err_r, 32'h1);
        chk("crit_stop", estop_active_r, 32'h1);
        chk("irq_set", irq_r, 32'h1);
        door_split <= 1'h0;
        stop_split <= 1'h0;
        st;
        rd(`SIM_OFS_STATUS, d);
        chk("crit_event", d[`SIM_EV_CRIT_DOOR + k], 32'h1);
        chk("stop_event", d[`SIM_EV_ESTOP], 32'h1);
        st;
        chk("irq_clr", irq_r, 32'h0);
        wr(`SIM_OFS_CONTROL, 32'h1);
        st;
        wr(`SIM_OFS_CONTROL, 32'h1);
        st;
        chk("crit_clr", critical_err_r, 32'h0);
        chk("crit_run", estop_active_r, 32'h0);
    end
    tally_and_finish;
end
endmodule
`default_nettype wire
